// ---- design/wws_pkg.sv ----
// Purpose: shared constants for the windowed watchdog supervisor
// Assumes: 100 MHz system clock, fixed times converted to cycles here, window options in wws_supervisor
// Notes: window tables hold the eight build-time timing options
package wws_pkg;
  // ----------------------------------------
  // clock rate
  // ----------------------------------------
  localparam longint WWS_CLK_PERIOD_NS = 10; // 100 MHz
  localparam longint WWS_CYC_PER_US = 1000 / WWS_CLK_PERIOD_NS;

  // ----------------------------------------
  // documented times, in their own units
  // ----------------------------------------
  localparam longint RESET_HOLD_TIME_MS = 100; // least hold after causes clear
  localparam longint WWS_PULSE_MS = 1; // fault pulse length
  localparam longint WWS_STROBE_MIN_NS = 300; // least strobe low width
  localparam longint WWS_MR_DEB_NS = 1000; // manual reset settle time

  // ----------------------------------------
  // derived cycle counts (least times round up)
  // ----------------------------------------
  localparam longint WWS_HOLD_CYC = (RESET_HOLD_TIME_MS * 1000 * WWS_CYC_PER_US);
  localparam longint WWS_PULSE_CYC = (WWS_PULSE_MS * 1000 * WWS_CYC_PER_US);
  localparam longint WWS_STROBE_CYC = (WWS_STROBE_MIN_NS + WWS_CLK_PERIOD_NS - 1) / WWS_CLK_PERIOD_NS;
  localparam longint WWS_MR_DEB_CYC = (WWS_MR_DEB_NS + WWS_CLK_PERIOD_NS - 1) / WWS_CLK_PERIOD_NS;

  // ----------------------------------------
  // window options A..H, in microseconds
  // ----------------------------------------
  localparam longint WWS_FAST_US [8] = '{1500, 15000, 15000, 15000, 15000, 23000, 39000, 719000};
  localparam longint WWS_SLOW_US [8] = '{10000, 100000, 300000, 10000000, 60000000, 47000, 82000, 1300000};

  // ----------------------------------------
  // counter widths
  // ----------------------------------------
  localparam int WWS_WD_W = 33; // fits 60 s of cycles
  localparam int WWS_HOLD_W = 24;
  localparam int WWS_PULSE_W = 17;
  localparam int WWS_STB_W = 5;
  localparam int WWS_DEB_W = 7;

  // ----------------------------------------
  // watchdog states
  // ----------------------------------------
  typedef enum logic [1:0] {
    WWS_WD_FIRST = 2'b00, // next edge is never judged early
    WWS_WD_ARMED = 2'b01, // full window check
    WWS_WD_PULSE = 2'b10 // fault pulse running
  } wws_wd_state_t;
endpackage : wws_pkg

// ---- design/wws_mr_if.sv ----
// Purpose: carries the manual reset level to its filter and back
// Assumes: one clock domain
// Notes: raw level in, debounced level out
`timescale 1ns/1ps
interface wws_mr_if;
  logic rawLevel_n; // pin level, active low
  logic stable_n; // debounced level, active low
  modport filt (input rawLevel_n, output stable_n);
  modport user (output rawLevel_n, input stable_n);
endinterface : wws_mr_if

// ---- design/wws_mr_debounce.sv ----
// Purpose: debounce filter for the manual reset input
// Assumes: input already synchronous to clk
// Notes: level must hold for the settle time before it is taken
`timescale 1ns/1ps
module wws_mr_debounce
  import wws_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  wws_mr_if.filt mr
);
  // ----------------------------------------
  // settle counter
  // ----------------------------------------
  localparam logic [WWS_DEB_W-1:0] DEB_LAST = WWS_DEB_W'(WWS_MR_DEB_CYC - 1);
  logic [WWS_DEB_W-1:0] cnt_r; // cycles the input has differed
  logic stable_r; // filtered level

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // short glitches restart the count, so they never reach the output
  always_ff @(posedge clk) begin
    if (reset) begin
      cnt_r <= '0;
      stable_r <= 1'b1; // released
    end else if (mr.rawLevel_n == stable_r) begin
      cnt_r <= '0; // agrees, nothing pending
    end else if (cnt_r == DEB_LAST) begin
      cnt_r <= '0;
      stable_r <= mr.rawLevel_n; // held long enough
    end else begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  assign mr.stable_n = stable_r;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  chk_deb_settle: assert property ($changed(stable_r) |-> $past(cnt_r) == DEB_LAST && $past(mr.rawLevel_n) == stable_r)
    else $error("manual reset changed before settle time");
endmodule : wws_mr_debounce

// ---- design/wws_supervisor.sv ----
// Purpose: reset supervisor with windowed watchdog and fault pulse
// Assumes: supplyLow comes from an outside comparator, inputs synchronous
// Notes: window option picked at build time by WIN_OPT
`timescale 1ns/1ps
module wws_supervisor
  import wws_pkg::*;
#(
  parameter int WIN_OPT = 0, // 0..7 for options A..H
  parameter logic [WWS_HOLD_W-1:0] HOLD_CYC = WWS_HOLD_W'(WWS_HOLD_CYC),
  parameter logic [WWS_PULSE_W-1:0] PULSE_CYC = WWS_PULSE_W'(WWS_PULSE_CYC),
  parameter logic [WWS_WD_W-1:0] FAST_CYC = WWS_WD_W'(WWS_FAST_US[WIN_OPT] * WWS_CYC_PER_US),
  parameter logic [WWS_WD_W-1:0] SLOW_CYC = WWS_WD_W'(WWS_SLOW_US[WIN_OPT] * WWS_CYC_PER_US)
)
(
  input wire logic clk,
  input wire logic reset,
  input wire logic supplyLow,
  input wire logic manualReset_n,
  input wire logic watchdogStrobeIn,
  input wire logic faultPulseIn_n,
  output logic resetOut_n,
  output logic faultPulseOut_n,
  output logic faultPulseOutOe
);
  // ----------------------------------------
  // local constants
  // ----------------------------------------
  localparam logic [WWS_STB_W-1:0] STB_LAST = WWS_STB_W'(WWS_STROBE_CYC - 1);
  localparam logic [WWS_WD_W-1:0] STB_START = WWS_WD_W'(WWS_STROBE_CYC);

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // ----------------------------------------
  // manual reset filter
  // ----------------------------------------
  wws_mr_if mrIf (); // raw and filtered manual reset
  logic mrHeld; // debounced manual reset active

  assign mrIf.rawLevel_n = manualReset_n;

  wws_mr_debounce uDeb (
    .clk(clk),
    .reset(reset),
    .mr(mrIf.filt)
  );

  assign mrHeld = !mrIf.stable_n;

  // ----------------------------------------
  // reset output and hold timer
  // ----------------------------------------
  logic [WWS_HOLD_W-1:0] holdCnt_r; // cycles since both causes cleared
  logic resetOut_r; // active low reset
  logic resetCause; // any reason to hold the processor

  assign resetCause = supplyLow || mrHeld;

  // any cause restarts the hold, so a bouncing supply keeps reset low
  always_ff @(posedge clk) begin
    if (reset) begin
      holdCnt_r <= '0;
      resetOut_r <= 1'b0; // power-on reset
    end else if (resetCause) begin
      holdCnt_r <= '0;
      resetOut_r <= 1'b0;
    end else if (!resetOut_r) begin
      if (holdCnt_r == HOLD_CYC - 1'b1) begin
        resetOut_r <= 1'b1; // hold served
      end else begin
        holdCnt_r <= holdCnt_r + 1'b1;
      end
    end
  end

  assign resetOut_n = resetOut_r;

  // ----------------------------------------
  // strobe qualification
  // ----------------------------------------
  logic [WWS_STB_W-1:0] stbCnt_r; // cycles strobe has been low
  logic strobeEdge; // qualified falling edge, one cycle

  // a low shorter than the least width is ignored as a glitch
  always_ff @(posedge clk) begin
    if (reset) begin
      stbCnt_r <= '0;
    end else if (watchdogStrobeIn) begin
      stbCnt_r <= '0; // high, rearm
    end else if (stbCnt_r <= STB_LAST) begin
      stbCnt_r <= stbCnt_r + 1'b1; // saturates just past last
    end
  end

  assign strobeEdge = !watchdogStrobeIn && (stbCnt_r == STB_LAST);

  // ----------------------------------------
  // watchdog window and fault pulse
  // ----------------------------------------
  wws_wd_state_t wdState_r; // window state
  logic [WWS_WD_W-1:0] wdTimer_r; // cycles since last falling edge
  logic [WWS_PULSE_W-1:0] pulseCnt_r; // fault pulse length counter
  logic faultOe_r; // drive fault pin low
  logic fastFault; // early edge seen
  logic slowFault; // window ran out
  logic wdRun; // watchdog allowed to judge

  assign wdRun = resetOut_r && !mrHeld;
  // first edge after reset or pulse is exempt
  assign fastFault = strobeEdge && (wdState_r == WWS_WD_ARMED) && (wdTimer_r < FAST_CYC);
  assign slowFault = !strobeEdge && (wdTimer_r >= SLOW_CYC - 1'b1);

  // watchdog sleeps through reset; monitoring starts fresh on release
  always_ff @(posedge clk) begin
    if (reset || !wdRun) begin
      wdState_r <= WWS_WD_FIRST;
      wdTimer_r <= '0;
      pulseCnt_r <= '0;
      faultOe_r <= 1'b0; // pin released
    end else begin
      case (wdState_r)
        WWS_WD_FIRST, WWS_WD_ARMED: begin
          if (fastFault || slowFault) begin
            wdState_r <= WWS_WD_PULSE;
            pulseCnt_r <= '0;
            faultOe_r <= 1'b1;
          end else if (strobeEdge) begin
            wdState_r <= WWS_WD_ARMED;
            wdTimer_r <= STB_START; // measured from the falling edge
          end else begin
            wdTimer_r <= wdTimer_r + 1'b1;
          end
        end
        WWS_WD_PULSE: begin
          if (pulseCnt_r == PULSE_CYC - 1'b1) begin
            faultOe_r <= 1'b0; // pulse done
            wdState_r <= WWS_WD_FIRST;
            wdTimer_r <= '0;
          end else begin
            pulseCnt_r <= pulseCnt_r + 1'b1;
          end
        end
        default: begin
          wdState_r <= WWS_WD_FIRST;
        end
      endcase
    end
  end

  // ----------------------------------------
  // open-drain fault pin
  // ----------------------------------------
  // drive value is constant low; only the enable moves
  always_ff @(posedge clk) begin
    if (reset) begin
      faultPulseOut_n <= 1'b0;
    end else begin
      faultPulseOut_n <= 1'b0;
    end
  end

  assign faultPulseOutOe = faultOe_r;

  // ----------------------------------------
  // helper for hold check
  // ----------------------------------------
  logic [WWS_HOLD_W:0] clearCnt_r; // cycles both causes clear, saturating

  always_ff @(posedge clk) begin
    if (reset || resetCause) begin
      clearCnt_r <= '0;
    end else if (!clearCnt_r[WWS_HOLD_W]) begin
      clearCnt_r <= clearCnt_r + 1'b1;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  chk_reset_on_supply: assert property (supplyLow |=> !resetOut_n)
    else $error("reset not asserted on low supply");
  chk_reset_on_manual: assert property (mrHeld |=> !resetOut_n)
    else $error("reset not asserted on manual reset");
  chk_hold_min: assert property ($rose(resetOut_n) |-> clearCnt_r >= {1'b0, HOLD_CYC})
    else $error("reset released before hold time");
  chk_fast_fault: assert property (wdRun && fastFault && wdState_r != WWS_WD_PULSE |=> faultPulseOutOe)
    else $error("early strobe edge not flagged");
  chk_slow_fault: assert property (wdRun && wdState_r != WWS_WD_PULSE && wdTimer_r == SLOW_CYC - 1'b1
    && !strobeEdge |=> faultPulseOutOe)
    else $error("missing strobe edge not flagged");
  chk_edge_restart: assert property (wdRun && strobeEdge && !fastFault && wdState_r != WWS_WD_PULSE
    |=> wdTimer_r == STB_START && wdState_r == WWS_WD_ARMED)
    else $error("strobe edge did not restart window");
  chk_pulse_width: assert property ($fell(faultPulseOutOe) && $past(wdRun) |-> $past(pulseCnt_r) == PULSE_CYC - 1'b1)
    else $error("fault pulse length wrong");
  chk_od_low: assert property (faultPulseOutOe |-> !faultPulseOut_n)
    else $error("fault pin enabled while not low");
  chk_first_exempt: assert property (wdRun && wdState_r == WWS_WD_FIRST && strobeEdge
    && wdTimer_r < SLOW_CYC - 1'b1 |=> !faultPulseOutOe)
    else $error("first strobe edge judged early");
  chk_mr_clears: assert property (mrHeld |=> wdTimer_r == '0 && !faultPulseOutOe)
    else $error("manual reset left watchdog running");
  chk_pulse_restart: assert property ($fell(faultPulseOutOe) |-> wdTimer_r == '0 && wdState_r == WWS_WD_FIRST)
    else $error("window not restarted after pulse");
endmodule : wws_supervisor

// ---- tb/wws_host_model.sv ----
// Purpose: host processor model driving the watchdog strobe
// Assumes: one clock, strobe period set by the bench
// Notes: strobe idles high while the host is stopped
`timescale 1ns/1ps
module wws_host_model (
  input wire logic clk,
  input wire logic run,
  input wire logic [15:0] gapCyc,
  output logic strobe
);
  // ----------------------------------------
  // strobe pacing
  // ----------------------------------------
  logic [15:0] cnt_r; // cycles since last falling edge
  // wraps at gapCyc, so edges come exactly gapCyc apart
  always_ff @(posedge clk) begin
    if (!run || cnt_r >= gapCyc - 16'h0001) begin
      cnt_r <= 16'h0000;
    end else begin
      cnt_r <= cnt_r + 16'h0001;
    end
  end
  // low for 40 cycles, safely above the 30-cycle minimum width
  assign strobe = !(run && cnt_r < 16'h0028);
endmodule : wws_host_model

// ---- tb/testbench.sv ----
// Purpose: self-checking bench for the supervisor
// Assumes: shortened hold, pulse and window counts
// Notes: fault wire is pulled up outside the block
`timescale 1ns/1ps
module testbench;
  import wws_pkg::*;
  // ----------------------------------------
  // shortened counts
  // ----------------------------------------
  localparam int HOLD = 50;
  localparam int PULSE = 20;
  localparam int SLOW = 1000;
  logic clk = 1'b0, reset = 1'b1, supplyLow = 1'b0, manualReset_n = 1'b1, run = 1'b0;
  logic [15:0] gapCyc = 16'h01F4; // strobe spacing
  logic strobe, resetOut_n, faultPulseOut_n, faultPulseOutOe, faultWire_n;
  int fail_count = 0, n_compared = 0, c;
  always #5 clk = ~clk;
  // open-drain wire with pull-up
  assign faultWire_n = faultPulseOutOe ? faultPulseOut_n : 1'b1;
  wws_host_model host (.clk(clk), .run(run), .gapCyc(gapCyc), .strobe(strobe));
  wws_supervisor #(.WIN_OPT(0), .HOLD_CYC(24'h0032), .PULSE_CYC(17'h0014),
    .FAST_CYC(33'h0000_00C8), .SLOW_CYC(33'h0000_03E8)) dut (
    .clk(clk), .reset(reset), .supplyLow(supplyLow), .manualReset_n(manualReset_n),
    .watchdogStrobeIn(strobe), .faultPulseIn_n(faultWire_n), .resetOut_n(resetOut_n),
    .faultPulseOut_n(faultPulseOut_n), .faultPulseOutOe(faultPulseOutOe));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic close_out;
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : close_out
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: %s seen %0h want %0h", $time, what, seen, exp);
    end
  endtask : check
  // inputs change 1 ns after the edge, outputs settled by then
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  // selectors for the bounded wait
  localparam int W_RST = 0; // watch the reset output
  localparam int W_OE = 1; // watch the fault pin enable
  // bounded wait; running out ends the run as a mismatch
  task automatic wait_for(input int sel, input logic val, input int bound, output int cyc);
    cyc = 0;
    while (((sel == W_RST) ? resetOut_n : faultPulseOutOe) !== val && cyc < bound) begin
      tick(1);
      cyc++;
    end
    if (((sel == W_RST) ? resetOut_n : faultPulseOutOe) !== val) begin
      fail_count++;
      $display("unexpected at %0t: wait ran out", $time);
      close_out();
    end
  endtask : wait_for
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  // build-time tables against the documented figures
  task automatic s_options;
    check(32'(WWS_HOLD_CYC), 32'h0098_9680, "hold cycles");
    check(32'(WWS_PULSE_CYC), 32'h0001_86A0, "pulse cycles");
    check(32'(WWS_FAST_US[0]), 32'h0000_05DC, "option A fast");
    check(32'(WWS_SLOW_US[0]), 32'h0000_2710, "option A slow");
    check(32'(WWS_FAST_US[7]), 32'h000A_F898, "option H fast");
    check(32'(WWS_SLOW_US[7]), 32'h0013_D620, "option H slow");
  endtask : s_options
  task automatic s_reset_hold;
    reset = 1'b1;
    tick(2);
    reset = 1'b0;
    check(resetOut_n, 1'b0, "reset held");
    wait_for(W_RST, 1'b1, HOLD + 10, c);
    check(c >= HOLD, 1'b1, "hold too short");
  endtask : s_reset_hold
  task automatic s_supply;
    supplyLow = 1'b1;
    tick(2);
    check(resetOut_n, 1'b0, "supply low reset");
    supplyLow = 1'b0;
    wait_for(W_RST, 1'b1, HOLD + 10, c);
    check(c >= HOLD, 1'b1, "supply hold");
  endtask : s_supply
  task automatic s_manual;
    manualReset_n = 1'b0;
    tick(50);
    manualReset_n = 1'b1;
    tick(60);
    check(resetOut_n, 1'b1, "glitch taken");
    manualReset_n = 1'b0;
    tick(110);
    check(resetOut_n, 1'b0, "manual reset");
    manualReset_n = 1'b1;
    wait_for(W_RST, 1'b1, HOLD + 120, c);
    check(c >= HOLD, 1'b1, "manual hold");
  endtask : s_manual
  task automatic s_good;
    int faults;
    faults = 0;
    s_reset_hold();
    gapCyc = 16'h01F4;
    run = 1'b1;
    repeat (3000) begin
      tick(1);
      if (faultPulseOutOe !== 1'b0) faults++;
    end
    check(faults, 0, "fault on good strobes");
    run = 1'b0;
  endtask : s_good
  task automatic s_fast;
    s_reset_hold();
    gapCyc = 16'h0064;
    run = 1'b1;
    wait_for(W_OE, 1'b1, 400, c);
    check(c >= 100, 1'b1, "first edge judged early");
    check(c <= 200, 1'b1, "early edge missed");
    check(faultWire_n, 1'b0, "wire not pulled");
    wait_for(W_OE, 1'b0, PULSE + 5, c);
    check(c, PULSE, "pulse width");
    check(faultWire_n, 1'b1, "wire not released");
    // first edge after the pulse is exempt, so the next fault needs two more edges
    wait_for(W_OE, 1'b1, 400, c);
    check(c >= 100, 1'b1, "edge after pulse judged early");
    wait_for(W_OE, 1'b0, PULSE + 5, c);
    check(c, PULSE, "second pulse width");
    run = 1'b0;
  endtask : s_fast
  task automatic s_slow;
    s_reset_hold();
    wait_for(W_OE, 1'b1, SLOW + 50, c);
    check(c, SLOW, "slow fault time");
    wait_for(W_OE, 1'b0, PULSE + 5, c);
    check(c, PULSE, "slow pulse width");
    wait_for(W_OE, 1'b1, SLOW + 50, c);
    check(c, SLOW, "no restart");
    wait_for(W_OE, 1'b0, PULSE + 5, c);
    // manual reset timed to settle part way through the next pulse
    tick(SLOW - int'(WWS_MR_DEB_CYC) + 10);
    manualReset_n = 1'b0;
    wait_for(W_OE, 1'b1, 200, c);
    wait_for(W_OE, 1'b0, PULSE + 5, c);
    check(c < PULSE, 1'b1, "pulse not cut by manual");
    check(faultWire_n, 1'b1, "pin held in manual");
    check(resetOut_n, 1'b0, "manual reset");
    manualReset_n = 1'b1;
    wait_for(W_RST, 1'b1, HOLD + 120, c);
    check(c >= HOLD, 1'b1, "manual release hold");
  endtask : s_slow
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    s_reset_hold();
    s_supply();
    s_manual();
    s_good();
    s_fast();
    s_slow();
    s_options();
    close_out();
  end
endmodule : testbench
